// ===== design/lsar_defines.svh
// Purpose: Constants for the linear sweep and amplitude ramp engine
// Assumes: Register words are loaded whole through the load port
// Notes:   Field positions are bit indices inside each register word
`ifndef LSAR_DEFINES_SVH
`define LSAR_DEFINES_SVH

`define LSAR_ADDR_BASE     4'h4
`define LSAR_ADDR_AMPL     4'h6
`define LSAR_ADDR_RATES    4'h7
`define LSAR_ADDR_RISE     4'h8
`define LSAR_ADDR_FALL     4'h9
`define LSAR_ADDR_END      4'hA
`define LSAR_ADDR_CTRL     4'h3

`define LSAR_CTRL_PACLR    1
`define LSAR_CTRL_SACLR    3
`define LSAR_CTRL_PAUTO    2
`define LSAR_CTRL_SAUTO    4
`define LSAR_CTRL_RELOAD   13
`define LSAR_CTRL_SWEEP_EN 14
`define LSAR_CTRL_NODWELL  15
`define LSAR_CTRL_SEL_LO   22

`define LSAR_AMP_SCALE_HI  9
`define LSAR_AMP_AUTO      11
`define LSAR_AMP_MULT_EN   12
`define LSAR_AMP_STEP_LO   14
`define LSAR_AMP_RATE_LO   16

`define LSAR_RESET_WORD    32'h0000_0000
`define LSAR_TIMER_ONE     8'h01

`endif

// ===== design/lsar_pkg.sv
// Purpose: Types shared by the sweep engine files
// Assumes: Nothing beyond the constants header
// Notes:   Select codes follow the two-bit sweep parameter select field
package lsar_pkg;
	typedef enum logic [1:0] {
		LSAR_SEL_NONE = 2'h0,
		LSAR_SEL_AMPL = 2'h1,
		LSAR_SEL_FREQ = 2'h2,
		LSAR_SEL_PHAS = 2'h3
	} lsar_sel_t;

	typedef enum logic [2:0] {
		LSAR_ST_HOLD = 3'b001,
		LSAR_ST_RISE = 3'b010,
		LSAR_ST_FALL = 3'b100
	} lsar_state_t;
endpackage

// ===== design/lsar_rate_timer.sv
// Purpose: Eight-bit loadable down counter giving one step pulse per interval
// Assumes: A load value of zero is treated as one
// Notes:   Step pulse is registered; fires when count reaches one
`timescale 1ns/10ps
`include "lsar_defines.svh"
module lsar_rate_timer (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_en,
	input  wire logic       i_load,
	input  wire logic [7:0] i_load_val,
	input  wire logic [7:0] i_reload_val,
	output logic            o_step
);
	import lsar_pkg::*;

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       step_q;
	logic       step_d;

	always_comb begin
		cnt_d  = cnt_q;
		step_d = 1'b0;
		if (i_load) begin
			cnt_d = (i_load_val == 8'h00) ? `LSAR_TIMER_ONE : i_load_val;
		end else if (i_en) begin
			if (cnt_q <= `LSAR_TIMER_ONE) begin
				// Reload keeps period equal to rate word
				cnt_d  = (i_reload_val == 8'h00) ? `LSAR_TIMER_ONE : i_reload_val;
				step_d = 1'b1;
			end else begin
				cnt_d = cnt_q - 8'h01;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cnt_q  <= `LSAR_TIMER_ONE;
			step_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			step_q <= step_d;
		end
	end

	assign o_step = step_q;

	chk_step_single: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_en && !i_load && cnt_q == 8'h01) |=> o_step)
		else $error("step missing at count one");
	chk_load_value: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_load && i_load_val != 8'h00) |=> (cnt_q == $past(i_load_val)))
		else $error("timer load value lost");
endmodule

// ===== design/lsar_amp_ramp.sv
// Purpose: Output amplitude scale factor, manual or automatic ramp
// Assumes: Ramp direction level already synchronised
// Notes:   Ramp clamps at zero and at programmed scale factor
`timescale 1ns/10ps
`include "lsar_defines.svh"
module lsar_amp_ramp (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic [23:0] i_ampl,
	input  wire logic        i_dir_up,
	input  wire logic        i_dir_chg,
	output logic [9:0]       o_scale,
	output logic             o_bypass
);
	import lsar_pkg::*;

	logic [9:0] ramp_q;
	logic [9:0] ramp_d;
	logic       auto_q;
	logic [10:0] sum;
	logic [9:0] step;
	logic [9:0] limit;
	logic       mult_en;
	logic       auto_en;
	logic       tick;

	assign mult_en = i_ampl[`LSAR_AMP_MULT_EN];
	assign auto_en = mult_en & i_ampl[`LSAR_AMP_AUTO];
	assign limit   = i_ampl[`LSAR_AMP_SCALE_HI:0];
	assign step    = 10'h001 << i_ampl[`LSAR_AMP_STEP_LO +: 2];

	lsar_rate_timer u_timer (
		.i_mclk       (i_mclk),
		.i_rst        (i_rst),
		.i_en         (auto_en),
		.i_load       (i_dir_chg | (auto_en & ~auto_q)),
		.i_load_val   (i_ampl[`LSAR_AMP_RATE_LO +: 8]),
		.i_reload_val (i_ampl[`LSAR_AMP_RATE_LO +: 8]),
		.o_step       (tick)
	);

	always_comb begin
		ramp_d = ramp_q;
		sum    = 11'h000;
		if (!auto_en) begin
			ramp_d = 10'h000;
		end else if (tick) begin
			if (i_dir_up) begin
				sum    = {1'b0, ramp_q} + {1'b0, step};
				ramp_d = (sum > {1'b0, limit}) ? limit : sum[9:0];
			end else begin
				ramp_d = (ramp_q > step) ? ramp_q - step : 10'h000;
			end
		end
		if (auto_en && ramp_d > limit) begin
			ramp_d = limit;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ramp_q   <= 10'h000;
			auto_q   <= 1'b0;
			o_scale  <= 10'h000;
			o_bypass <= 1'b1;
		end else begin
			ramp_q   <= ramp_d;
			auto_q   <= auto_en;
			o_scale  <= auto_en ? ramp_d : limit;
			o_bypass <= ~mult_en;
		end
	end

	chk_ramp_limit: assert property (@(posedge i_mclk) disable iff (i_rst)
		auto_q |-> (ramp_q <= $past(limit)))
		else $error("ramp above scale limit");
	chk_bypass_follow: assert property (@(posedge i_mclk) disable iff (i_rst)
		!mult_en |=> o_bypass)
		else $error("multiplier not bypassed");
endmodule

// ===== design/lsar_sweep.sv
// Summary of operation
// - Step words: frequency 32, phase 14, amplitude 10
// - Eight-bit down timer reloads after reaching one
// - Step lasts ramp rate word clock periods
// - Rising words upward, falling words downward
// - Profile edge loads matching ramp rate
// - Update with reload bit loads rate by pin
// - Rising sweep adds until end, then holds
// - Dwell falling sweep steps down to start
// - No-dwell jumps back to start at end
// - No-dwell ignores falling rate and word
// - Autoclear bits: sweep bit 4, phase 2
// - Continuous clear: sweep bit 3, phase 1
// - Continuous clear holds accumulator at zero
// - Autoclear zeroes once per update or edge
// - Multiplier enable clear bypasses multiplier
// - Manual mode scales by written factor
// - Auto mode ramps ten-bit counter by pin
// - Step field selects 1, 2, 4, 8
// - Auto factor never exceeds programmed factor
// - Host directs ramp; device ramps zero to limit
// - Select 01 amplitude, 10 frequency, 11 phase
// - Start from base word, end from end word at address A
// - Each channel has its own profile pin
//
// Purpose: One channel of the linear sweep engine with amplitude ramp
// Assumes: i_mclk is the sync clock; words load through a simple write port
// Notes:   Phase and amplitude words are MSB aligned in 32-bit sweep words
`timescale 1ns/10ps
`include "lsar_defines.svh"
module lsar_sweep (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_wr,
	input  wire logic [3:0]  i_wr_addr,
	input  wire logic [31:0] i_wr_data,
	input  wire logic        i_update,
	input  wire logic        i_profile,
	input  wire logic        i_ramp_pin,
	output logic [31:0]      o_sweep_word,
	output lsar_pkg::lsar_sel_t o_sweep_sel,
	output logic             o_phase_clear,
	output logic [9:0]       o_scale,
	output logic             o_bypass
);
	import lsar_pkg::*;

	logic [31:0] base_q, end_q, rise_q, fall_q;
	logic [23:0] ampl_q, ctrl_q;
	logic [15:0] rates_q;
	logic [1:0]  prof_sync_q, ramp_sync_q;
	logic        prof_q, ramp_q;
	logic        prof_last_q, ramp_last_q;
	logic        upd_q;
	logic [31:0] acc_q, acc_d;
	logic        pclr_q, pclr_d;
	lsar_state_t st_q, st_d;
	logic        prof_rise, prof_fall, prof_chg, ramp_chg;
	logic        sweep_en, nodwell, timer_load, step;
	logic [7:0]  rate_rise, rate_fall, load_val, reload_val;
	logic [31:0] mask, step_rise, step_fall, lo_w, hi_w;
	logic [32:0] sum;
	lsar_sel_t   sel;

	assign sel       = lsar_sel_t'(ctrl_q[`LSAR_CTRL_SEL_LO +: 2]);
	assign sweep_en  = ctrl_q[`LSAR_CTRL_SWEEP_EN] && sel != LSAR_SEL_NONE;
	assign nodwell   = ctrl_q[`LSAR_CTRL_NODWELL];
	assign rate_rise = rates_q[7:0];
	assign rate_fall = rates_q[15:8];
	// Edges compare the synced level with its own delayed copy
	assign prof_rise = prof_q & ~prof_last_q;
	assign prof_fall = ~prof_q & prof_last_q & ~nodwell;
	assign prof_chg  = prof_q ^ prof_last_q;
	assign ramp_chg  = ramp_q ^ ramp_last_q;

	// Width mask keeps unused low bits out of the arithmetic
	always_comb begin
		unique case (sel)
			LSAR_SEL_AMPL: mask = 32'hFFC0_0000;
			LSAR_SEL_PHAS: mask = 32'hFFFC_0000;
			default:       mask = 32'hFFFF_FFFF;
		endcase
	end

	assign step_rise = rise_q & mask;
	assign step_fall = fall_q & mask;
	assign lo_w      = base_q & mask;
	assign hi_w      = end_q & mask;

	always_comb begin
		timer_load = 1'b0;
		load_val   = rate_rise;
		if (sweep_en && prof_rise) begin
			timer_load = 1'b1;
		end else if (sweep_en && prof_fall) begin
			timer_load = 1'b1;
			load_val   = rate_fall;
		end else if (sweep_en && upd_q && ctrl_q[`LSAR_CTRL_RELOAD]) begin
			timer_load = 1'b1;
			load_val   = (prof_q || nodwell) ? rate_rise : rate_fall;
		end
		reload_val = (st_q == LSAR_ST_FALL) ? rate_fall : rate_rise;
	end

	lsar_rate_timer u_timer (
		.i_mclk       (i_mclk),
		.i_rst        (i_rst),
		.i_en         (sweep_en),
		.i_load       (timer_load),
		.i_load_val   (load_val),
		.i_reload_val (reload_val),
		.o_step       (step)
	);

	lsar_amp_ramp u_amp (
		.i_mclk    (i_mclk),
		.i_rst     (i_rst),
		.i_ampl    (ampl_q),
		.i_dir_up  (ramp_q),
		.i_dir_chg (ramp_chg),
		.o_scale   (o_scale),
		.o_bypass  (o_bypass)
	);

	// Accumulator holds offset from start word
	always_comb begin
		acc_d  = acc_q;
		st_d   = st_q;
		sum    = 33'h0_0000_0000;
		pclr_d = ctrl_q[`LSAR_CTRL_PACLR];
		if ((upd_q || prof_chg) && ctrl_q[`LSAR_CTRL_PAUTO]) begin
			pclr_d = 1'b1;
		end
		if (sweep_en && prof_rise) begin
			st_d = LSAR_ST_RISE;
		end else if (sweep_en && prof_fall) begin
			st_d = LSAR_ST_FALL;
		end
		if (!sweep_en) begin
			st_d = LSAR_ST_HOLD;
		end else if (step && st_q == LSAR_ST_RISE) begin
			sum = {1'b0, acc_q} + {1'b0, step_rise};
			if (sum >= {1'b0, hi_w - lo_w}) begin
				acc_d = nodwell ? 32'h0000_0000 : hi_w - lo_w;
				st_d  = LSAR_ST_HOLD;
			end else begin
				acc_d = sum[31:0];
			end
		end else if (step && st_q == LSAR_ST_FALL) begin
			if (acc_q <= step_fall) begin
				acc_d = 32'h0000_0000;
				st_d  = LSAR_ST_HOLD;
			end else begin
				acc_d = acc_q - step_fall;
			end
		end
		if ((upd_q || prof_chg) && ctrl_q[`LSAR_CTRL_SAUTO]) begin
			acc_d = 32'h0000_0000;
		end
		if (ctrl_q[`LSAR_CTRL_SACLR]) begin
			acc_d = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			base_q  <= `LSAR_RESET_WORD;
			end_q   <= `LSAR_RESET_WORD;
			rise_q  <= `LSAR_RESET_WORD;
			fall_q  <= `LSAR_RESET_WORD;
			ampl_q  <= 24'h00_0000;
			ctrl_q  <= 24'h00_0000;
			rates_q <= 16'h0000;
		end else if (i_wr) begin
			unique case (i_wr_addr)
				`LSAR_ADDR_BASE:  base_q  <= i_wr_data;
				`LSAR_ADDR_END:   end_q   <= i_wr_data;
				`LSAR_ADDR_RISE:  rise_q  <= i_wr_data;
				`LSAR_ADDR_FALL:  fall_q  <= i_wr_data;
				`LSAR_ADDR_AMPL:  ampl_q  <= i_wr_data[23:0];
				`LSAR_ADDR_CTRL:  ctrl_q  <= i_wr_data[23:0];
				`LSAR_ADDR_RATES: rates_q <= i_wr_data[15:0];
				default:          ;
			endcase
		end
	end

	// Two flops on pins before any logic reads them
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			prof_sync_q  <= 2'b00;
			ramp_sync_q  <= 2'b00;
			prof_last_q  <= 1'b0;
			ramp_last_q  <= 1'b0;
			upd_q        <= 1'b0;
			acc_q        <= 32'h0000_0000;
			st_q         <= LSAR_ST_HOLD;
			pclr_q       <= 1'b0;
			o_sweep_word <= 32'h0000_0000;
			o_sweep_sel  <= LSAR_SEL_NONE;
			o_phase_clear <= 1'b0;
		end else begin
			prof_sync_q  <= {prof_sync_q[0], i_profile};
			ramp_sync_q  <= {ramp_sync_q[0], i_ramp_pin};
			prof_last_q  <= prof_sync_q[1];
			ramp_last_q  <= ramp_sync_q[1];
			upd_q        <= i_update;
			acc_q        <= acc_d;
			st_q         <= st_d;
			pclr_q       <= pclr_d;
			o_sweep_word <= lo_w + acc_d;
			o_sweep_sel  <= sweep_en ? sel : LSAR_SEL_NONE;
			o_phase_clear <= pclr_d;
		end
	end

	assign prof_q = prof_sync_q[1];
	assign ramp_q = ramp_sync_q[1];

	sequence s_rise_edge;
		sweep_en && prof_rise && !ctrl_q[`LSAR_CTRL_SACLR];
	endsequence

	chk_rise_state: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_rise_edge |=> st_q == LSAR_ST_RISE)
		else $error("rising sweep not started");
	chk_cont_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
		ctrl_q[`LSAR_CTRL_SACLR] |=> acc_q == 32'h0000_0000)
		else $error("accumulator not held at zero");
	chk_end_clamp: assert property (@(posedge i_mclk) disable iff (i_rst)
		(sweep_en && !nodwell && hi_w >= lo_w) |-> acc_q <= hi_w - lo_w)
		else $error("sweep overshoot");
	chk_nodwell_fall: assert property (@(posedge i_mclk) disable iff (i_rst)
		nodwell |-> st_q != LSAR_ST_FALL)
		else $error("falling sweep in no-dwell");
endmodule

// ===== testbench/lsar_host.sv
// Purpose: Host model driving write port, update strobe and control pins
// Assumes: Every output changes just after a rising clock edge
// Notes:   Pins are raw levels; the design synchronises them itself
`timescale 1ns/10ps
module lsar_host (
	input  wire logic   i_mclk,
	output logic        o_wr,
	output logic [3:0]  o_wr_addr,
	output logic [31:0] o_wr_data,
	output logic        o_update,
	output logic        o_profile,
	output logic        o_ramp_pin
);
	// Modulation level outside this block is taken as two-level
	initial begin
		o_wr       = 1'b0;
		o_wr_addr  = 4'h0;
		o_wr_data  = 32'h0000_0000;
		o_update   = 1'b0;
		o_profile  = 1'b0;
		o_ramp_pin = 1'b0;
	end
	// Strobe drops for a cycle so back-to-back calls never collide
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		o_wr      <= 1'b1;
		o_wr_addr <= a;
		o_wr_data <= d;
		@(posedge i_mclk);
		o_wr <= 1'b0;
	endtask
	task automatic upd();
		@(posedge i_mclk);
		o_update <= 1'b1;
		@(posedge i_mclk);
		o_update <= 1'b0;
	endtask
	// One profile pin serves this channel alone
	task automatic prof(input logic v);
		@(posedge i_mclk);
		o_profile <= v;
	endtask
	task automatic ramp(input logic v);
		@(posedge i_mclk);
		o_ramp_pin <= v;
	endtask
endmodule

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for one sweep channel
// Assumes: Host model owns every design input except clock and reset
// Notes:   Step timing is measured between output changes, not absolute
`timescale 1ns/10ps
`include "lsar_defines.svh"
module testbench;
	import lsar_pkg::*;
	logic        i_mclk = 1'b0;
	logic        i_rst  = 1'b1;
	logic        wr, upd_s, prof_s, ramp_s, pclr, byp;
	logic [3:0]  wa;
	logic [31:0] wd, word, hi, lo;
	logic [9:0]  scale;
	lsar_sel_t   sel;
	logic        pc_seen;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          n;
	always #5 i_mclk = ~i_mclk;
	lsar_host host (.i_mclk(i_mclk), .o_wr(wr), .o_wr_addr(wa), .o_wr_data(wd),
		.o_update(upd_s), .o_profile(prof_s), .o_ramp_pin(ramp_s));
	lsar_sweep DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr(wr), .i_wr_addr(wa),
		.i_wr_data(wd), .i_update(upd_s), .i_profile(prof_s), .i_ramp_pin(ramp_s),
		.o_sweep_word(word), .o_sweep_sel(sel), .o_phase_clear(pclr),
		.o_scale(scale), .o_bypass(byp));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic ticks(input int k);
		repeat (k) @(posedge i_mclk);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// Cycles between two consecutive changes of the sweep word
	task automatic gap(output int g);
		logic [31:0] w;
		int          i;
		w = word;
		i = 0;
		while (word === w && i < 60) begin
			ticks(1);
			i++;
		end
		w = word;
		g = 0;
		while (word === w && g < 60) begin
			ticks(1);
			g++;
		end
	endtask
	task automatic watch(input int k);
		hi      = word;
		lo      = word;
		pc_seen = 1'b0;
		repeat (k) begin
			ticks(1);
			if (word > hi) hi = word;
			if (word < lo) lo = word;
			if (pclr === 1'b1) pc_seen = 1'b1;
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		summarize();
	end
	initial begin
		ticks(4);
		i_rst <= 1'b0;
		ticks(2);
		check(byp, 32'h0000_0001);
		check(scale, 32'h0000_0000);
		check(word, 32'h0000_0000);
		done("reset");
		for (int s = 1; s < 4; s++) begin
			host.wr(`LSAR_ADDR_CTRL, (s << 22) | 32'h0000_4000);
			ticks(2);
			check(sel, s);
		end
		host.wr(`LSAR_ADDR_CTRL, 32'h0080_0000);
		ticks(2);
		check(sel, LSAR_SEL_NONE);
		done("select");
		host.wr(`LSAR_ADDR_BASE, 32'h0000_0064);
		host.wr(`LSAR_ADDR_RATES, 32'h0000_0304);
		host.wr(`LSAR_ADDR_RISE, 32'h0000_0005);
		host.wr(`LSAR_ADDR_FALL, 32'h0000_0007);
		host.wr(`LSAR_ADDR_END, 32'h0000_007A);
		host.wr(4'h5, 32'hFFFF_FFFF);
		host.wr(4'hB, 32'hFFFF_FFFF);
		host.wr(`LSAR_ADDR_CTRL, 32'h0080_4000);
		ticks(3);
		check(word, 32'h0000_0064);
		host.prof(1'b1);
		gap(n);
		check(n, 32'h0000_0004);
		ticks(40);
		check(word, 32'h0000_007A);
		host.prof(1'b0);
		gap(n);
		check(n, 32'h0000_0003);
		ticks(40);
		check(word, 32'h0000_0064);
		done("dwell");
		host.wr(`LSAR_ADDR_CTRL, 32'h0080_C000);
		host.prof(1'b1);
		watch(60);
		check(hi > 32'h0000_0073, 32'h0000_0001);
		check(word, 32'h0000_0064);
		host.prof(1'b0);
		watch(30);
		check(hi, 32'h0000_0064);
		host.prof(1'b1);
		watch(60);
		check(hi > 32'h0000_0073, 32'h0000_0001);
		done("nodwell");
		host.wr(`LSAR_ADDR_CTRL, 32'h0080_400A);
		ticks(10);
		check(word, 32'h0000_0064);
		check(pclr, 32'h0000_0001);
		host.wr(`LSAR_ADDR_CTRL, 32'h0080_4000);
		ticks(3);
		check(pclr, 32'h0000_0000);
		host.prof(1'b0);
		ticks(40);
		host.prof(1'b1);
		ticks(40);
		check(word, 32'h0000_007A);
		host.wr(`LSAR_ADDR_CTRL, 32'h0080_4014);
		repeat (2) begin
			host.upd();
			watch(20);
			check(lo, 32'h0000_0064);
			check(pc_seen, 32'h0000_0001);
		end
		done("clear");
		host.wr(`LSAR_ADDR_AMPL, 32'h0000_0155);
		ticks(3);
		check(byp, 32'h0000_0001);
		host.wr(`LSAR_ADDR_AMPL, 32'h0000_1155);
		ticks(3);
		check(byp, 32'h0000_0000);
		check(scale, 32'h0000_0155);
		for (int k = 0; k < 4; k++) begin
			host.ramp(1'b0);
			host.wr(`LSAR_ADDR_AMPL, 32'h0002_13FF);
			host.wr(`LSAR_ADDR_AMPL, 32'h0002_1BFF | (k << 14));
			ticks(4);
			check(scale, 32'h0000_0000);
			host.ramp(1'b1);
			n = 0;
			while (scale === 10'h000 && n < 40) begin
				ticks(1);
				n++;
			end
			check(scale, 32'h0000_0001 << k);
		end
		host.ramp(1'b0);
		host.wr(`LSAR_ADDR_AMPL, 32'h0001_D80F);
		ticks(30);
		host.ramp(1'b1);
		ticks(20);
		check(scale, 32'h0000_000F);
		host.ramp(1'b0);
		ticks(20);
		check(scale, 32'h0000_0000);
		done("amplitude");
		summarize();
	end
endmodule
